/* File: ocss_params.svh */
// constants for the output clock source select block
// assumes inclusion by bare name from the package and design modules
`ifndef OCSS_PARAMS_SVH
`define OCSS_PARAMS_SVH

// register byte addresses
`define OCSS_ADDR_SYNC_LOW    8'ha8
`define OCSS_ADDR_FOUR_FIVE   8'ha9
`define OCSS_ADDR_SIX_SEVEN   8'haa
`define OCSS_ADDR_RESERVED    8'hab

// field positions in sync_and_low_output_source
`define OCSS_LOW_SEL_LSB      0
`define OCSS_LOW_SEL_MSB      3
`define OCSS_SYNC0_BIT        4
`define OCSS_SYNC1_BIT        5

// field positions in the two three-bit select registers
`define OCSS_LO_FIELD_LSB     0
`define OCSS_LO_FIELD_MSB     2
`define OCSS_HI_FIELD_LSB     4
`define OCSS_HI_FIELD_MSB     6

// reset values
`define OCSS_RST_SYNC         1'b0
`define OCSS_RST_LOW_SEL      4'ha
`define OCSS_RST_SEL4         3'h0
`define OCSS_RST_SEL5         3'h2
`define OCSS_RST_SEL6         3'h0
`define OCSS_RST_SEL7         3'h5

// source codes of the three-bit selects
`define OCSS_SRC_LOOP0        3'h0
`define OCSS_SRC_LOOP1        3'h1
`define OCSS_SRC_OUT2         3'h2
`define OCSS_SRC_OUT3         3'h3
`define OCSS_SRC_REF0         3'h4
`define OCSS_SRC_REF1         3'h5
`define OCSS_SRC_RSVD         3'h6
`define OCSS_SRC_XTAL         3'h7

// one-bit select codes
`define OCSS_LOW_LOOP0        1'b0

// read value of reserved positions
`define OCSS_RSVD_READ        8'h00

`endif

/* File: ocss_pkg.sv */
// types shared by the output clock source select block
// assumes ocss_params.svh is on the include path
package ocss_pkg;
   `include "ocss_params.svh"

   typedef enum logic {
      OCSS_SYNC_RUN,
      OCSS_SYNC_HOLD
   } ocss_sync_state_e;

   typedef logic [2:0] ocss_src_code_t;
   typedef logic [1:0] ocss_loop_mask_t;
endpackage : ocss_pkg

/* File: ocss_sync_ctrl.sv */
// one loop's output sync sequencer
// assumes sync_bit_in is a register bit in the mclk_in domain
`timescale 1ns/1ps
module ocss_sync_ctrl
   import ocss_pkg::*;
(
   input  wire logic mclk_in,
   input  wire logic rst_n_in,
   input  wire logic sync_bit_in,
   output logic      hold_out,
   output logic      release_out
);

   ocss_sync_state_e state;

   // rising bit enters hold, falling bit releases once
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state       <= OCSS_SYNC_RUN;
         hold_out    <= 1'b0;
         release_out <= 1'b0;
      end else begin
         release_out <= 1'b0;
         case (state)
            OCSS_SYNC_RUN: begin
               if (sync_bit_in) begin
                  state    <= OCSS_SYNC_HOLD;
                  hold_out <= 1'b1;
               end
            end
            OCSS_SYNC_HOLD: begin
               if (!sync_bit_in) begin
                  state       <= OCSS_SYNC_RUN;
                  hold_out    <= 1'b0;
                  release_out <= 1'b1;
               end
            end
            default: begin
               state    <= OCSS_SYNC_RUN;
               hold_out <= 1'b0;
            end
         endcase
      end
   end

endmodule : ocss_sync_ctrl

/* File: ocss_source_select.sv */
// output clock source select and output divider sync control
// assumes a byte register port driven by the device's register access
// logic, and divider, phase and mux logic outside that obey the outputs
`timescale 1ns/1ps
`include "ocss_params.svh"
module ocss_source_select
   import ocss_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   output logic      [3:0] out_low_source_select_out,
   output logic      [2:0] out4_source_select_out,
   output logic      [2:0] out5_source_select_out,
   output logic      [2:0] out6_source_select_out,
   output logic      [2:0] out7_source_select_out,
   output logic      [7:4] source_valid_out,
   output logic      [7:0] divider_reset_out,
   output logic      [7:0] coarse_clear_out,
   output logic      [1:0] fine_load_out
);

   logic           first_loop_output_sync;
   logic           second_loop_output_sync;
   ocss_src_code_t sel4;
   ocss_src_code_t sel5;
   ocss_src_code_t sel6;
   ocss_src_code_t sel7;
   logic [1:0]     hold;
   logic [1:0]     release_pulse;
   logic [7:0]     next_loop0_member;
   logic [7:0]     next_loop1_member;
   logic [7:4]     next_valid;
   logic [7:0]     next_rdata;

   // loop membership of a three-bit select; outputs 2,3 inherit their loop
   function automatic ocss_loop_mask_t loop_of_code(
      input ocss_src_code_t code,
      input logic           sel_out2,
      input logic           sel_out3
   );
      ocss_loop_mask_t m;
      m = 2'b00;
      case (code)
         `OCSS_SRC_LOOP0: m = 2'b01;
         `OCSS_SRC_LOOP1: m = 2'b10;
         `OCSS_SRC_OUT2:
            m = (sel_out2 == `OCSS_LOW_LOOP0) ? 2'b01 : 2'b10;
         `OCSS_SRC_OUT3:
            m = (sel_out3 == `OCSS_LOW_LOOP0) ? 2'b01 : 2'b10;
         default: m = 2'b00;
      endcase
      return m;
   endfunction : loop_of_code

   // register writes; reserved positions are dropped
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         first_loop_output_sync    <= `OCSS_RST_SYNC;
         second_loop_output_sync   <= `OCSS_RST_SYNC;
         out_low_source_select_out <= `OCSS_RST_LOW_SEL;
         sel4                      <= `OCSS_RST_SEL4;
         sel5                      <= `OCSS_RST_SEL5;
         sel6                      <= `OCSS_RST_SEL6;
         sel7                      <= `OCSS_RST_SEL7;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `OCSS_ADDR_SYNC_LOW: begin
               out_low_source_select_out <= reg_wdata_in
                  [`OCSS_LOW_SEL_MSB:`OCSS_LOW_SEL_LSB];
               first_loop_output_sync  <=
                  reg_wdata_in[`OCSS_SYNC0_BIT];
               second_loop_output_sync <=
                  reg_wdata_in[`OCSS_SYNC1_BIT];
            end
            `OCSS_ADDR_FOUR_FIVE: begin
               sel4 <= reg_wdata_in
                  [`OCSS_LO_FIELD_MSB:`OCSS_LO_FIELD_LSB];
               sel5 <= reg_wdata_in
                  [`OCSS_HI_FIELD_MSB:`OCSS_HI_FIELD_LSB];
            end
            `OCSS_ADDR_SIX_SEVEN: begin
               sel6 <= reg_wdata_in
                  [`OCSS_LO_FIELD_MSB:`OCSS_LO_FIELD_LSB];
               sel7 <= reg_wdata_in
                  [`OCSS_HI_FIELD_MSB:`OCSS_HI_FIELD_LSB];
            end
            default: begin
            end
         endcase
      end
   end

   // read mux; reserved positions read zero
   always_comb begin
      next_rdata = `OCSS_RSVD_READ;
      case (reg_addr_in)
         `OCSS_ADDR_SYNC_LOW: begin
            next_rdata[`OCSS_LOW_SEL_MSB:`OCSS_LOW_SEL_LSB] =
               out_low_source_select_out;
            next_rdata[`OCSS_SYNC0_BIT] = first_loop_output_sync;
            next_rdata[`OCSS_SYNC1_BIT] = second_loop_output_sync;
         end
         `OCSS_ADDR_FOUR_FIVE: begin
            next_rdata[`OCSS_LO_FIELD_MSB:`OCSS_LO_FIELD_LSB] = sel4;
            next_rdata[`OCSS_HI_FIELD_MSB:`OCSS_HI_FIELD_LSB] = sel5;
         end
         `OCSS_ADDR_SIX_SEVEN: begin
            next_rdata[`OCSS_LO_FIELD_MSB:`OCSS_LO_FIELD_LSB] = sel6;
            next_rdata[`OCSS_HI_FIELD_MSB:`OCSS_HI_FIELD_LSB] = sel7;
         end
         default: next_rdata = `OCSS_RSVD_READ;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= `OCSS_RSVD_READ;
      end else if (reg_rd_in) begin
         reg_rdata_out <= next_rdata;
      end
   end

   // one sequencer per loop
   ocss_sync_ctrl u_sync_first (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .sync_bit_in (first_loop_output_sync),
      .hold_out    (hold[0]),
      .release_out (release_pulse[0])
   );

   ocss_sync_ctrl u_sync_second (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .sync_bit_in (second_loop_output_sync),
      .hold_out    (hold[1]),
      .release_out (release_pulse[1])
   );

   // which outputs each loop drives
   always_comb begin
      ocss_loop_mask_t m4;
      ocss_loop_mask_t m5;
      ocss_loop_mask_t m6;
      ocss_loop_mask_t m7;
      m4 = loop_of_code(sel4, out_low_source_select_out[2],
                        out_low_source_select_out[3]);
      m5 = loop_of_code(sel5, out_low_source_select_out[2],
                        out_low_source_select_out[3]);
      m6 = loop_of_code(sel6, out_low_source_select_out[2],
                        out_low_source_select_out[3]);
      m7 = loop_of_code(sel7, out_low_source_select_out[2],
                        out_low_source_select_out[3]);
      next_loop0_member[3:0] = ~out_low_source_select_out;
      next_loop1_member[3:0] = out_low_source_select_out;
      next_loop0_member[7:4] = {m7[0], m6[0], m5[0], m4[0]};
      next_loop1_member[7:4] = {m7[1], m6[1], m5[1], m4[1]};
   end

   // the reserved code, and the ref1 code on output 6, leave the output without a source
   always_comb begin
      next_valid[4] = (sel4 != `OCSS_SRC_RSVD);
      next_valid[5] = (sel5 != `OCSS_SRC_RSVD);
      next_valid[6] = (sel6 != `OCSS_SRC_REF1) &&
                      (sel6 != `OCSS_SRC_RSVD);
      next_valid[7] = (sel7 != `OCSS_SRC_RSVD);
   end

   // mux selects follow the register the cycle after the write
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         out4_source_select_out <= `OCSS_RST_SEL4;
         out5_source_select_out <= `OCSS_RST_SEL5;
         out6_source_select_out <= `OCSS_RST_SEL6;
         out7_source_select_out <= `OCSS_RST_SEL7;
         source_valid_out       <= 4'hf;
      end else begin
         out4_source_select_out <= sel4;
         out5_source_select_out <= sel5;
         out6_source_select_out <= sel6;
         out7_source_select_out <= sel7;
         source_valid_out       <= next_valid;
      end
   end

   // divider resets, each loop's outputs released on the same edge
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         divider_reset_out <= 8'h00;
      end else begin
         divider_reset_out <= ({8{hold[0]}} & next_loop0_member) |
                              ({8{hold[1]}} & next_loop1_member);
      end
   end

   // coarse phase clear on release
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         coarse_clear_out <= 8'h00;
      end else begin
         coarse_clear_out <=
            ({8{release_pulse[0]}} & next_loop0_member) |
            ({8{release_pulse[1]}} & next_loop1_member);
      end
   end

   // fine phase load for outputs 2 and 3 on the driving loop's release
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         fine_load_out <= 2'b00;
      end else begin
         fine_load_out <=
            ({2{release_pulse[0]}} & next_loop0_member[3:2]) |
            ({2{release_pulse[1]}} & next_loop1_member[3:2]);
      end
   end

endmodule : ocss_source_select

/* File: ocss_source_select_sva.sv */
// checker for the output clock source select block
// assumes it is bound onto ocss_source_select
`timescale 1ns/1ps
module ocss_source_select_chk (
   input wire logic       mclk_in,
   input wire logic       rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [3:0] out_low_source_select_out,
   input wire logic [2:0] out4_source_select_out,
   input wire logic [2:0] out5_source_select_out,
   input wire logic [2:0] out6_source_select_out,
   input wire logic [2:0] out7_source_select_out,
   input wire logic [7:0] divider_reset_out,
   input wire logic [7:0] coarse_clear_out,
   input wire logic [1:0] fine_load_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   reset_values_a: assert property ($rose(rst_n_in) |->
      out_low_source_select_out == 4'ha && divider_reset_out == 8'h00)
      else $error("reset values wrong");
   low_sel_write_a: assert property (
      reg_wr_in && reg_addr_in == 8'ha8 |=>
      out_low_source_select_out == $past(reg_wdata_in[3:0]))
      else $error("low select not written");
   out4_follow_a: assert property (
      reg_wr_in && reg_addr_in == 8'ha9 |=> ##1
      out4_source_select_out == $past(reg_wdata_in[2:0], 2))
      else $error("output 4 mux code wrong");
   release_clear_a: assert property (
      |($past(divider_reset_out) & ~divider_reset_out) &&
      $past(out_low_source_select_out) ==
      $past(out_low_source_select_out, 2) &&
      $stable(out4_source_select_out) && $stable(out5_source_select_out) &&
      $stable(out6_source_select_out) && $stable(out7_source_select_out) |->
      coarse_clear_out == ($past(divider_reset_out) & ~divider_reset_out))
      else $error("release without matching clear");
   clear_pulse_a: assert property (|coarse_clear_out |=>
      (coarse_clear_out & $past(coarse_clear_out)) == 8'h00)
      else $error("clear pulse too long");
   fine_load_a: assert property (
      fine_load_out == coarse_clear_out[3:2])
      else $error("fine load not with clear");
   loop0_group_a: assert property (
      !(out_low_source_select_out[0] | out_low_source_select_out[2]) &&
      !($past(out_low_source_select_out[0]) |
        $past(out_low_source_select_out[2])) |->
      divider_reset_out[0] == divider_reset_out[2])
      else $error("loop 0 dividers differ");
   read_low_a: assert property (reg_rd_in && reg_addr_in == 8'ha8 |=>
      reg_rdata_out == {4'h0, $past(out_low_source_select_out)} ||
      reg_rdata_out[7:6] == 2'b00 && reg_rdata_out[3:0] ==
      $past(out_low_source_select_out)) else $error("read of a8 wrong");
   read_rsvd_a: assert property (reg_rd_in && reg_addr_in == 8'hab |=>
      reg_rdata_out == 8'h00) else $error("reserved read not zero");
endmodule : ocss_source_select_chk

bind ocss_source_select ocss_source_select_chk u_chk (
   .mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
   .reg_rd_in, .reg_rdata_out, .out_low_source_select_out,
   .out4_source_select_out, .out5_source_select_out,
   .out6_source_select_out, .out7_source_select_out,
   .divider_reset_out, .coarse_clear_out,
   .fine_load_out
);

/* File: test_output_clock_source_select.sv */
// testbench for the output clock source select block
// assumes ocss_pkg, the design and the checker are compiled first
`timescale 1ns/1ps
module test_output_clock_source_select;
   import ocss_pkg::*;
   logic       mclk_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic       reg_wr_in = 1'b0;
   logic       reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out, divider_reset_out, coarse_clear_out, got;
   logic [3:0] out_low_source_select_out;
   logic [2:0] out4_source_select_out, out5_source_select_out;
   logic [2:0] out6_source_select_out, out7_source_select_out;
   logic [7:4] source_valid_out;
   logic [1:0] fine_load_out;
   int         fails = 0;
   int         compares = 0;
   int         cyc = 0;

   ocss_source_select u_dut (
      .mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .out_low_source_select_out,
      .out4_source_select_out, .out5_source_select_out,
      .out6_source_select_out, .out7_source_select_out, .source_valid_out,
      .divider_reset_out, .coarse_clear_out, .fine_load_out
   );

   always #10 mclk_in = ~mclk_in;

   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic ticks(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : ticks

   task automatic wr(input logic [7:0] a, d);
      ticks(1);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      ticks(1);
      reg_wr_in = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      ticks(1);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      ticks(1);
      reg_rd_in = 1'b0;
      got = reg_rdata_out;
   endtask : rd

   task automatic t_reset();
      chk("low", {4'h0, out_low_source_select_out}, 8'h0a);
      chk("s45", {1'b0, out5_source_select_out, 1'b0,
         out4_source_select_out}, 8'h20);
      chk("s67", {1'b0, out7_source_select_out, 1'b0,
         out6_source_select_out}, 8'h50);
      chk("div", divider_reset_out | coarse_clear_out, 8'h00);
      rd(8'ha8);
      chk("r_a8", got, 8'h0a);
      rd(8'haa);
      chk("r_aa", got, 8'h50);
   endtask : t_reset

   task automatic t_codes();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         wr(8'ha9, {1'b0, c, 1'b0, c});
         wr(8'haa, {1'b0, c, 1'b0, c});
         ticks(1);
         chk("s45", {1'b0, out5_source_select_out, 1'b0,
            out4_source_select_out}, {1'b0, c, 1'b0, c});
         chk("s67", {1'b0, out7_source_select_out, 1'b0,
            out6_source_select_out}, {1'b0, c, 1'b0, c});
         rd(8'haa);
         chk("r_aa", got, {1'b0, c, 1'b0, c});
         chk("val", {4'h0, source_valid_out}, {4'h0, c != 3'h6,
            c != 3'h5 && c != 3'h6, c != 3'h6, c != 3'h6});
      end
   endtask : t_codes

   task automatic t_rsvd();
      wr(8'ha8, 8'hca);
      rd(8'ha8);
      chk("r_a8", got, 8'h0a);
      wr(8'ha9, 8'hff);
      rd(8'ha9);
      chk("r_a9", got, 8'h77);
      wr(8'hab, 8'hff);
      rd(8'hab);
      chk("r_ab", got, 8'h00);
      wr(8'h10, 8'h5a);
      rd(8'h10);
      chk("r_10", got, 8'h00);
   endtask : t_rsvd

   task automatic t_sync();
      wr(8'ha9, 8'h24);
      wr(8'haa, 8'h31);
      wr(8'ha8, 8'h1a);
      ticks(2);
      chk("div", divider_reset_out, 8'h25);
      wr(8'ha8, 8'h3a);
      ticks(2);
      chk("div", divider_reset_out, 8'hef);
      wr(8'ha8, 8'h2a);
      ticks(2);
      chk("div", divider_reset_out, 8'hca);
      chk("clr", coarse_clear_out, 8'h25);
      chk("fine", {6'h0, fine_load_out}, 8'h01);
      ticks(1);
      chk("clr", coarse_clear_out, 8'h00);
      wr(8'ha8, 8'h0a);
      ticks(2);
      chk("clr", coarse_clear_out, 8'hca);
      chk("fine", {6'h0, fine_load_out}, 8'h02);
   endtask : t_sync

   task automatic t_swap();
      ticks(1);
      reg_addr_in = 8'ha8;
      reg_wdata_in = 8'h05;
      reg_wr_in = 1'b1;
      reg_rd_in = 1'b1;
      ticks(1);
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      chk("old", reg_rdata_out, 8'h0a);
      chk("low", {4'h0, out_low_source_select_out}, 8'h05);
      wr(8'ha8, 8'h15);
      ticks(2);
      chk("div", divider_reset_out, 8'h8a);
      wr(8'ha8, 8'h05);
      ticks(2);
      chk("clr", coarse_clear_out, 8'h8a);
      chk("fine", {6'h0, fine_load_out}, 8'h02);
   endtask : t_swap

   initial begin
      ticks(20);
      rst_n_in = 1'b1;
      t_reset();
      t_codes();
      t_rsvd();
      t_sync();
      t_swap();
      rst_n_in = 1'b0;
      ticks(2);
      rst_n_in = 1'b1;
      t_reset();
      stop_test();
   end
endmodule : test_output_clock_source_select
